// File: iss_defs.svh
// Encodings, field positions and reset values of the slave engine.
// Assumes inclusion by the package and by the engine; definitions only.
`ifndef ISS_DEFS_SVH
`define ISS_DEFS_SVH
// Bit counter: counts SCL rising edges of one byte plus its ack slot
`define ISS_CNT_W 4
`define ISS_CNT_ONE 4'h1
`define ISS_BIT_ACK 4'h8
`define ISS_BIT_END 4'h9
// First byte of a 10-bit address: 11110 A9 A8 R/W
`define ISS_TEN_HI 5'h1E
// One-hot state codes
`define ISS_ST_W 5
`define ISS_ST_IDLE 5'h01
`define ISS_ST_ADDR 5'h02
`define ISS_ST_ADLO 5'h04
`define ISS_ST_RXD 5'h08
`define ISS_ST_TXD 5'h10
// Reset values
`define ISS_ADDR_RST 8'h00
`define ISS_CKP_RST 1'b1
`endif

// File: iss_pkg.sv
// Types shared by the slave engine and its bench.
// Assumes iss_defs.svh in the include path.
`include "iss_defs.svh"
package iss_pkg;
    typedef enum logic [`ISS_ST_W-1:0] {
        S_IDLE = `ISS_ST_IDLE,
        S_ADDR = `ISS_ST_ADDR,
        S_ADLO = `ISS_ST_ADLO,
        S_RXD = `ISS_ST_RXD,
        S_TXD = `ISS_ST_TXD
    } iss_state_t;

    // Configuration levels held by software
    typedef struct packed {
        logic tenBit;
        logic addressHoldEn;
        logic dataHoldEn;
        logic stretchEnable;
        logic startIrqEn;
        logic slaveCollisionDetectEn;
        logic ackValue;
    } iss_cfg_t;

    // One-cycle software strobes; wdata goes with bufWrite and addrWrite
    typedef struct packed {
        logic bufWrite;
        logic bufRead;
        logic addrWrite;
        logic ckpSet;
        logic irqClear;
        logic collisionClear;
        logic [7:0] wdata;
    } iss_sw_t;

    typedef struct packed {
        logic clockRelease;
        logic ackStatus;
        logic ackTime;
        logic readWrite;
        logic dataNotAddr;
        logic startSeen;
        logic stopSeen;
        logic bufferFull;
        logic updateAddress;
        logic serialIrqFlag;
        logic busCollisionFlag;
    } iss_stat_t;
endpackage

// File: iss_sync.sv
// Two-flop synchronisers with edge detection, one per bus line.
// Assumes asynchronous pin inputs; outputs are in the clk domain.
`timescale 1ns/1ps
module iss_sync #(
    parameter int W = 2
) (
    // Clock
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Lines
    input wire logic [W-1:0] din,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_line
            logic meta, s1, s2;
            // Idle bus level is high, so reset to one avoids false edges
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta <= 1'b1;
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                end else if (ce) begin
                    meta <= din[i];
                    s1 <= meta;
                    s2 <= s1;
                end
            end
            assign lvl[i] = s1;
            assign rise[i] = s1 && !s2;
            assign fall[i] = !s1 && s2;
        end
    endgenerate
endmodule // iss_sync

// File: iss_cond.sv
// Start and stop condition detector on synchronised SCL and SDA.
// Assumes inputs from iss_sync in the same clock domain.
`timescale 1ns/1ps
module iss_cond (
    // Synchronised lines
    input wire logic sclS,
    input wire logic sdaRise,
    input wire logic sdaFall,
    // Conditions, one-cycle pulses
    output logic startDet,
    output logic stopDet
);
    // SDA may only change with SCL high at a start or a stop
    assign startDet = sclS && sdaFall;
    assign stopDet = sclS && sdaRise;
endmodule // iss_cond

// File: iss_slave.sv
// I2C slave engine: read requests, address hold, 10-bit addressing, stretching.
// Assumes open-drain pins resolved outside; software bits arrive as ports.
// Notes on behaviour
// [R1] Matching read address: set read flag, buffer the address, acknowledge.
// [R2] After acking a read request, clear clock release and hold SCL low.
// [R3] Software buffer write also loads the shift register; then sets clock release.
// [R4] Transmit bits change on SCL falling edges, stable while SCL high.
// [R5] Master ack latched on ninth rising edge into ack status.
// [R6] A not-acknowledge ends the transfer; wait idle for a new start.
// [R7] On master not-acknowledge, do not hold SCL, still raise the interrupt flag.
// [R8] On master acknowledge, stretch again until software reloads and releases.
// [R9] Interrupt flag set on ninth falling edge per byte; software clears it.
// [R10] Collision while sending with detect enabled: flag it, go idle.
// [R11] Start sets start-seen; interrupt only if start interrupts enabled.
// [R12] Address hold: after 8th fall clear release, hold SCL, raise interrupt.
// [R13] Address hold: software picks ack value, releases; engine drives that value.
// [R14] Software load sets buffer full; loads belong after the address ack.
// [R15] Master must not-acknowledge its last read byte before stopping.
// [R16] Restart or stop drops the addressed state.
// [R17] 10-bit matching high write byte: set update-address, ack, interrupt.
// [R18] Software writes low address after ack; that write releases SCL.
// [R19] Low byte mismatch: interrupt and update-address set, buffer and release untouched.
// [R20] 10-bit reception with stretch enable: stretch after each data byte.
// [R21] Software buffer read clears buffer full.
// [R22] Cleared release holds SCL once low; setting it releases SCL.
// [R23] 10-bit with holds stretches as 7-bit plus the address update.
// [R24] 10-bit high byte compares against 11110, address bits 2:1, direction.
// [R25] Stretch enable holds SCL after each received byte until released.
`timescale 1ns/1ps
`include "iss_defs.svh"
module iss_slave (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Bus pins, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe,
    // Software side
    input wire iss_pkg::iss_cfg_t cfg,
    input wire iss_pkg::iss_sw_t sw,
    output logic [7:0] bufData,
    output logic [7:0] slaveAddr,
    output iss_pkg::iss_stat_t stat
);
    iss_pkg::iss_state_t state_r;
    logic [`ISS_CNT_W-1:0] bitCnt_r;
    logic [7:0] shiftReg_r, bufData_r, slaveAddr_r;
    logic txBit_r, ackDrive_r, ackUseSw_r, sdaLow_r, sclHold_r;
    logic ckp_r, ackStatus_r, ackTime_r, readWrite_r, dataNotAddr_r;
    logic startSeen_r, stopSeen_r, bufferFull_r, updateAddr_r, irqFlag_r, collFlag_r, tenDone_r;
    logic sclS, sdaS, sclRise, sclFall, sdaRise, sdaFall, startDet, stopDet;
    logic inIdle, inAddr, inLo, inRx, inTx;
    logic dataRise, ackRise, fall8, fall9, addrMatch, loMatch;
    logic addrHit, loHit, rxByte, holdHere, ackSent, colDet, uaSet, ckpClr, irqSet;

    iss_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din({sclIn, sdaIn}),
        .lvl({sclS, sdaS}),
        .rise({sclRise, sdaRise}),
        .fall({sclFall, sdaFall})
    );

    iss_cond u_cond (
        .sclS(sclS),
        .sdaRise(sdaRise),
        .sdaFall(sdaFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    always_comb begin
        inIdle = state_r == iss_pkg::S_IDLE;
        inAddr = state_r == iss_pkg::S_ADDR;
        inLo = state_r == iss_pkg::S_ADLO;
        inRx = state_r == iss_pkg::S_RXD;
        inTx = state_r == iss_pkg::S_TXD;
        dataRise = sclRise && (bitCnt_r < `ISS_BIT_ACK);
        ackRise = sclRise && (bitCnt_r == `ISS_BIT_ACK);
        fall8 = sclFall && (bitCnt_r == `ISS_BIT_ACK);
        fall9 = sclFall && (bitCnt_r == `ISS_BIT_END);
        // A 10-bit read is only honoured after a full write-address match
        addrMatch = cfg.tenBit ?
            (shiftReg_r[7:3] == `ISS_TEN_HI) && (shiftReg_r[2:1] == slaveAddr_r[2:1])
                && (!shiftReg_r[0] || tenDone_r) :
            (shiftReg_r[7:1] == slaveAddr_r[7:1]); // see [R24]
        loMatch = shiftReg_r == slaveAddr_r;
        addrHit = fall8 && inAddr && addrMatch;
        loHit = fall8 && inLo && loMatch;
        // A full buffer on a data byte is an overflow: no ack
        rxByte = fall8 && inRx && !bufferFull_r;
        holdHere = (addrHit && cfg.addressHoldEn) || (rxByte && cfg.dataHoldEn); // see [R12] see [R23]
        ackSent = ackDrive_r && !(ackUseSw_r && cfg.ackValue); // see [R13]
        colDet = dataRise && inTx && txBit_r && !sdaS && cfg.slaveCollisionDetectEn; // see [R10]
        uaSet = fall9 && ((inAddr && ackSent && !readWrite_r && cfg.tenBit && !tenDone_r)
            || inLo); // see [R17] see [R19]
        ckpClr = holdHere || (fall9 && (
            (inAddr && ackSent && (readWrite_r || (cfg.stretchEnable && !uaSet))) // see [R2]
            || (inRx && ackSent && cfg.stretchEnable) // see [R20] see [R25]
            || (inTx && !ackStatus_r))); // see [R8] see [R7]
        irqSet = holdHere || (startDet && cfg.startIrqEn) || uaSet
            || (fall9 && (ackSent || inTx)); // see [R9] see [R11]
    end

    // Byte sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= iss_pkg::S_IDLE;
            bitCnt_r <= '0;
        end else if (ce) begin
            if (stopDet || colDet) begin
                state_r <= iss_pkg::S_IDLE; // see [R16] see [R10]
                bitCnt_r <= '0;
            end else if (startDet) begin
                state_r <= iss_pkg::S_ADDR; // see [R16]
                bitCnt_r <= '0;
            end else if (fall9) begin
                bitCnt_r <= '0;
                case (state_r)
                    iss_pkg::S_TXD: begin
                        state_r <= ackStatus_r ? iss_pkg::S_IDLE : iss_pkg::S_TXD; // see [R6]
                    end
                    iss_pkg::S_ADDR: begin
                        if (!ackSent)
                            state_r <= iss_pkg::S_IDLE;
                        else if (readWrite_r)
                            state_r <= iss_pkg::S_TXD;
                        else if (uaSet)
                            state_r <= iss_pkg::S_ADLO;
                        else
                            state_r <= iss_pkg::S_RXD;
                    end
                    iss_pkg::S_ADLO, iss_pkg::S_RXD: begin
                        state_r <= ackSent ? iss_pkg::S_RXD : iss_pkg::S_IDLE;
                    end
                    default: begin
                        state_r <= iss_pkg::S_IDLE;
                    end
                endcase
            end else if (fall8 && inAddr && !addrMatch) begin
                state_r <= iss_pkg::S_IDLE;
            end else if (sclRise && !inIdle && bitCnt_r < `ISS_BIT_END) begin
                bitCnt_r <= bitCnt_r + `ISS_CNT_ONE;
            end
        end
    end

    // Acknowledge slot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackDrive_r <= 1'b0;
            ackUseSw_r <= 1'b0;
        end else if (ce) begin
            if (startDet || stopDet || fall9) begin
                ackDrive_r <= 1'b0;
                ackUseSw_r <= 1'b0;
            end else if (fall8) begin
                ackDrive_r <= addrHit || loHit || rxByte; // see [R1] see [R17]
                ackUseSw_r <= holdHere; // see [R13]
            end
        end
    end

    // Shift register, shared by reception and transmission
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shiftReg_r <= '0;
            txBit_r <= 1'b1;
        end else if (ce) begin
            if (!inTx || fall8 || fall9) begin
                txBit_r <= 1'b1;
                if (dataRise && !inTx)
                    shiftReg_r <= {shiftReg_r[6:0], sdaS};
            end else if (sw.bufWrite) begin
                txBit_r <= sw.wdata[7]; // see [R3]
                shiftReg_r <= {sw.wdata[6:0], 1'b1};
            end else if (sclFall && bitCnt_r < `ISS_BIT_ACK) begin
                txBit_r <= shiftReg_r[7]; // see [R4]
                shiftReg_r <= {shiftReg_r[6:0], 1'b1};
            end
        end
    end

    // Line drivers; SCL hold waits for SCL already low so high time is never cut
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdaLow_r <= 1'b0;
            sclHold_r <= 1'b0;
        end else if (ce) begin
            sdaLow_r <= (inTx && bitCnt_r < `ISS_BIT_ACK && !txBit_r) || ackSent; // see [R1] see [R4]
            if (ckp_r && !updateAddr_r)
                sclHold_r <= 1'b0; // see [R22] see [R18]
            else if (!sclS)
                sclHold_r <= 1'b1; // see [R22]
        end
    end

    // Clock release and transfer status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ckp_r <= `ISS_CKP_RST;
            ackStatus_r <= 1'b0;
            ackTime_r <= 1'b0;
            readWrite_r <= 1'b0;
            dataNotAddr_r <= 1'b0;
            startSeen_r <= 1'b0;
            stopSeen_r <= 1'b0;
        end else if (ce) begin
            // Hardware clear wins: a stretch must never be lost
            if (ckpClr)
                ckp_r <= 1'b0;
            else if (sw.ckpSet)
                ckp_r <= 1'b1;
            if (ackRise && inTx)
                ackStatus_r <= sdaS; // see [R5]
            if (fall9 || startDet || stopDet)
                ackTime_r <= 1'b0;
            else if (holdHere)
                ackTime_r <= 1'b1;
            if (addrHit) begin
                readWrite_r <= shiftReg_r[0]; // see [R1]
                dataNotAddr_r <= 1'b0;
            end else if (rxByte || (inTx && fall8)) begin
                dataNotAddr_r <= 1'b1;
            end
            if (startDet) begin
                startSeen_r <= 1'b1; // see [R11]
                stopSeen_r <= 1'b0;
            end else if (stopDet) begin
                startSeen_r <= 1'b0;
                stopSeen_r <= 1'b1;
            end
        end
    end

    // Data buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bufData_r <= '0;
            bufferFull_r <= 1'b0;
        end else if (ce) begin
            if (sw.bufWrite)
                bufData_r <= sw.wdata;
            else if (addrHit || loHit || rxByte)
                bufData_r <= shiftReg_r; // see [R1]
            if (sw.bufWrite || addrHit || loHit || rxByte)
                bufferFull_r <= 1'b1; // see [R14] see [R19]
            else if (sw.bufRead || (inTx && fall8))
                bufferFull_r <= 1'b0; // see [R21]
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqFlag_r <= 1'b0;
            collFlag_r <= 1'b0;
        end else if (ce) begin
            if (irqSet)
                irqFlag_r <= 1'b1; // see [R9]
            else if (sw.irqClear)
                irqFlag_r <= 1'b0;
            if (colDet)
                collFlag_r <= 1'b1; // see [R10]
            else if (sw.collisionClear)
                collFlag_r <= 1'b0;
        end
    end

    // Slave address and 10-bit bookkeeping
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slaveAddr_r <= `ISS_ADDR_RST;
            updateAddr_r <= 1'b0;
            tenDone_r <= 1'b0;
        end else if (ce) begin
            if (sw.addrWrite)
                slaveAddr_r <= sw.wdata;
            if (uaSet)
                updateAddr_r <= 1'b1; // see [R17] see [R19]
            else if (sw.addrWrite)
                updateAddr_r <= 1'b0; // see [R18]
            if (stopDet)
                tenDone_r <= 1'b0;
            else if (fall9 && inLo && ackSent)
                tenDone_r <= 1'b1; // see [R23]
        end
    end

    assign sclOut = 1'b0;
    assign sclOe = sclHold_r;
    assign sdaOut = 1'b0;
    assign sdaOe = sdaLow_r;
    assign bufData = bufData_r;
    assign slaveAddr = slaveAddr_r;
    assign stat = '{clockRelease: ckp_r, ackStatus: ackStatus_r, ackTime: ackTime_r,
        readWrite: readWrite_r, dataNotAddr: dataNotAddr_r, startSeen: startSeen_r,
        stopSeen: stopSeen_r, bufferFull: bufferFull_r, updateAddress: updateAddr_r,
        serialIrqFlag: irqFlag_r, busCollisionFlag: collFlag_r};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence s_txNack;
        fall9 && inTx && ackStatus_r;
    endsequence
    sequence s_txAck;
        fall9 && inTx && !ackStatus_r;
    endsequence

    property p_readAck;
        addrHit && shiftReg_r[0] && !cfg.addressHoldEn |=> ackDrive_r && bufferFull_r && readWrite_r;
    endproperty
    a_readAck: assert property (p_readAck) else $error("read address not acknowledged"); // see [R1]
    property p_readStretch;
        fall9 && inAddr && ackSent && readWrite_r |=> !ckp_r && inTx ##1 sclHold_r;
    endproperty
    a_readStretch: assert property (p_readStretch) else $error("no stretch after read ack"); // see [R2]
    property p_load;
        sw.bufWrite && inTx && !fall8 && !fall9 |=> bufferFull_r && txBit_r == $past(sw.wdata[7]);
    endproperty
    a_load: assert property (p_load) else $error("buffer write did not load shifter"); // see [R3]
    property p_txStable;
        !sclFall && !sw.bufWrite && !(!inTx && !txBit_r) |=> $stable(txBit_r);
    endproperty
    a_txStable: assert property (p_txStable) else $error("tx bit moved off a falling edge"); // see [R4]
    property p_ackLatch;
        ackRise && inTx |=> ackStatus_r == $past(sdaS);
    endproperty
    a_ackLatch: assert property (p_ackLatch) else $error("ack not latched"); // see [R5]
    property p_nack;
        s_txNack |=> inIdle && irqFlag_r && ckp_r == $past(ckp_r);
    endproperty
    a_nack: assert property (p_nack) else $error("nack handling wrong"); // see [R6]
    property p_ackAgain;
        s_txAck |=> !ckp_r && irqFlag_r ##1 sclHold_r;
    endproperty
    a_ackAgain: assert property (p_ackAgain) else $error("no stretch after master ack"); // see [R8]
    property p_coll;
        colDet |=> inIdle && collFlag_r;
    endproperty
    a_coll: assert property (p_coll) else $error("collision not handled"); // see [R10]
    property p_start;
        startDet |=> startSeen_r && inAddr && (irqFlag_r || !cfg.startIrqEn);
    endproperty
    a_start: assert property (p_start) else $error("start not recorded"); // see [R11]
    property p_aHold;
        addrHit && cfg.addressHoldEn |=> !ckp_r && irqFlag_r && ackTime_r;
    endproperty
    a_aHold: assert property (p_aHold) else $error("address hold missing"); // see [R12]
    property p_release;
        ckp_r && !updateAddr_r |=> !sclHold_r;
    endproperty
    a_release: assert property (p_release) else $error("SCL held while released"); // see [R22]
    property p_uaClear;
        sw.addrWrite && !uaSet |=> !updateAddr_r ##1 ($past(ckp_r) -> !sclHold_r);
    endproperty
    a_uaClear: assert property (p_uaClear) else $error("address write did not release"); // see [R18]
endmodule // iss_slave

// File: iss_master_model.sv
// Behavioural I2C bus master that drives the slave engine in the bench.
// Assumes pulled-up lines resolved by the bench; it waits out clock stretching.
`timescale 1ns/1ps
module iss_master_model (
    // Resolved bus
    input wire logic sclLine,
    input wire logic sdaLine,
    // Pull-downs
    output logic sclLow,
    output logic sdaLow
);
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    // Release SCL, then wait while the slave stretches it
    task automatic sclUp();
        sclLow = 1'b0;
        repeat (4000) if (!sclLine) #40;
    endtask
    // SDA moves 40 ns after SCL falls so the slave never sees a false condition
    // Low phase of 240 ns gives the slave six clocks to move SDA before SCL rises
    task automatic bitX(input logic b, output logic r);
        #40 sdaLow = !b;
        #200;
        sclUp();
        #40 r = sdaLine;
        #40 sclLow = 1'b1;
    endtask
    task automatic startC();
        #40 sdaLow = 1'b0;
        #120;
        sclUp();
        #80 sdaLow = 1'b1;
        #80 sclLow = 1'b1;
    endtask
    task automatic stopC();
        #40 sdaLow = 1'b1;
        #120;
        sclUp();
        #80 sdaLow = 1'b0;
        #160;
    endtask
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(d[i], r);
        bitX(1'b1, r);
        ack = !r;
    endtask
    // Collide pulls SDA low on the first bit while the slave sends a one
    task automatic rdByte(input logic ackIt, input logic collide, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(!(collide && i == 7), d[i]);
        bitX(!ackIt, r);
    endtask
endmodule // iss_master_model

// File: tb_iss.sv
// Self-checking bench for the slave engine, driven through a bus master model.
// Assumes iss_pkg, iss_defs.svh and iss_master_model on the compile list.
`timescale 1ns/1ps
module tb;
    localparam logic [5:0] W_BUF = 6'h20, W_READ = 6'h10, W_ADDR = 6'h08, W_CKP = 6'h04, W_IRQC = 6'h02;
    logic clk, rst, ce, sclLow, sdaLow, sclOut, sclOe, sdaOut, sdaOe, ack;
    logic [7:0] bufData, slaveAddr, rd;
    iss_pkg::iss_cfg_t cfg;
    iss_pkg::iss_sw_t sw;
    iss_pkg::iss_stat_t stat;
    wire logic sclLine = !(sclLow || sclOe);
    wire logic sdaLine = !(sdaLow || sdaOe);
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    iss_slave uut (.clk(clk), .rst(rst), .ce(ce), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
        .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .cfg(cfg), .sw(sw), .bufData(bufData),
        .slaveAddr(slaveAddr), .stat(stat));
    iss_master_model master (.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));
    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run needs about 1300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end
    task automatic chkBit(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %b", $time, m, got);
        end
    endtask
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One-cycle software strobe with its data
    task automatic swOp(input logic [5:0] m, input logic [7:0] d);
        @(posedge clk);
        #2 sw = iss_pkg::iss_sw_t'({m, d});
        @(posedge clk);
        #2 sw = '0;
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
        #2;
    endtask
    task automatic holdAddr(input logic av, input logic expAck);
        master.startC();
        fork
            master.wrByte(8'h85, ack);
            begin
                for (int i = 0; i < 400 && stat.serialIrqFlag !== 1'b1; i++) @(posedge clk);
                settle();
                chkBit(stat.clockRelease, 1'b0, "hold rel");
                chkBit(sclOe, 1'b1, "hold scl");
                chkBit(stat.ackTime, 1'b1, "hold tim");
                cfg.ackValue = av;
                swOp(W_IRQC, 8'h00);
                swOp(W_CKP, 8'h00);
            end
        join
        chkBit(ack, expAck, "hold ack");
        if (expAck) begin
            settle();
            swOp(W_BUF, 8'h5A);
            swOp(W_CKP, 8'h00);
            master.rdByte(1'b0, 1'b0, rd);
            chkByte(rd, 8'h5A, "hold data");
        end
        master.stopC();
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cfg = '0;
        sw = '0;
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        repeat (4) @(posedge clk);
        chkBit(stat.clockRelease, 1'b1, "rst rel");
        chkByte(slaveAddr, 8'h00, "rst addr");
        chkBit(sclOut || sdaOut || sclOe || sdaOe, 1'b0, "rst pins");
        swOp(W_ADDR, 8'h84);
        master.startC();
        settle();
        chkBit(stat.startSeen, 1'b1, "start");
        chkBit(stat.serialIrqFlag, 1'b0, "start irq off");
        master.wrByte(8'h85, ack);
        settle();
        chkBit(ack, 1'b1, "addr ack");
        chkBit(stat.readWrite, 1'b1, "rw");
        chkByte(bufData, 8'h85, "addr buf");
        chkBit(stat.clockRelease, 1'b0, "rd rel");
        chkBit(sclOe, 1'b1, "rd scl");
        chkBit(stat.serialIrqFlag, 1'b1, "addr irq");
        swOp(W_IRQC, 8'h00);
        swOp(W_READ, 8'h00);
        chkBit(stat.bufferFull, 1'b0, "bf read");
        swOp(W_BUF, 8'hA5);
        chkBit(stat.bufferFull, 1'b1, "bf load");
        swOp(W_CKP, 8'h00);
        master.rdByte(1'b1, 1'b0, rd);
        settle();
        chkByte(rd, 8'hA5, "tx byte");
        chkBit(stat.dataNotAddr, 1'b1, "tx da");
        chkBit(stat.ackStatus, 1'b0, "ack st");
        chkBit(stat.serialIrqFlag, 1'b1, "tx irq");
        chkBit(sclOe, 1'b1, "ack stretch");
        swOp(W_IRQC, 8'h00);
        swOp(W_BUF, 8'h3C);
        swOp(W_CKP, 8'h00);
        master.rdByte(1'b0, 1'b0, rd);
        settle();
        chkByte(rd, 8'h3C, "tx last");
        chkBit(stat.ackStatus, 1'b1, "nack st");
        chkBit(stat.serialIrqFlag, 1'b1, "nack irq");
        chkBit(sclOe, 1'b0, "nack free");
        master.rdByte(1'b0, 1'b0, rd);
        chkByte(rd, 8'hFF, "idle");
        master.stopC();
        settle();
        chkBit(stat.stopSeen, 1'b1, "stop");
        cfg.startIrqEn = 1'b1;
        cfg.slaveCollisionDetectEn = 1'b1;
        swOp(W_IRQC, 8'h00);
        master.startC();
        settle();
        chkBit(stat.serialIrqFlag, 1'b1, "start irq");
        master.wrByte(8'h85, ack);
        settle();
        swOp(W_IRQC, 8'h00);
        swOp(W_BUF, 8'h80);
        swOp(W_CKP, 8'h00);
        master.rdByte(1'b0, 1'b1, rd);
        settle();
        chkBit(stat.busCollisionFlag, 1'b1, "coll");
        chkBit(sclOe, 1'b0, "coll idle");
        swOp(6'h01, 8'h00);
        chkBit(stat.busCollisionFlag, 1'b0, "coll clr");
        master.stopC();
        cfg.startIrqEn = 1'b0;
        cfg.addressHoldEn = 1'b1;
        swOp(W_IRQC, 8'h00);
        holdAddr(1'b1, 1'b0);
        holdAddr(1'b0, 1'b1);
        cfg.addressHoldEn = 1'b0;
        cfg.tenBit = 1'b1;
        swOp(W_ADDR, 8'hF6);
        master.startC();
        master.wrByte(8'hF6, ack);
        settle();
        chkBit(ack, 1'b1, "hi ack");
        chkBit(stat.updateAddress, 1'b1, "hi ua");
        chkBit(sclOe, 1'b1, "hi scl");
        swOp(W_READ, 8'h00);
        swOp(W_IRQC, 8'h00);
        swOp(W_ADDR, 8'h5A);
        settle();
        chkBit(stat.updateAddress, 1'b0, "ua clr");
        chkBit(sclOe, 1'b0, "lo free");
        master.wrByte(8'h5B, ack);
        settle();
        chkBit(ack, 1'b0, "lo nack");
        chkBit(stat.updateAddress, 1'b1, "lo ua");
        chkBit(stat.serialIrqFlag, 1'b1, "lo irq");
        chkBit(stat.bufferFull, 1'b0, "lo bf");
        chkBit(stat.clockRelease, 1'b1, "lo rel");
        swOp(W_ADDR, 8'hF6);
        master.stopC();
        // Full 10-bit match, then a data byte with stretching enabled
        cfg.stretchEnable = 1'b1;
        master.startC();
        master.wrByte(8'hF6, ack);
        settle();
        swOp(W_READ, 8'h00);
        swOp(W_ADDR, 8'h5A);
        master.wrByte(8'h5A, ack);
        settle();
        chkBit(ack, 1'b1, "lo ack");
        chkByte(bufData, 8'h5A, "lo buf");
        swOp(W_READ, 8'h00);
        swOp(W_ADDR, 8'hF6);
        master.wrByte(8'h3C, ack);
        settle();
        chkBit(ack, 1'b1, "rx ack");
        chkBit(stat.clockRelease, 1'b0, "rx rel");
        chkBit(sclOe, 1'b1, "rx scl");
        chkByte(bufData, 8'h3C, "rx buf");
        swOp(W_READ, 8'h00);
        chkBit(stat.bufferFull, 1'b0, "rx bf");
        swOp(W_CKP, 8'h00);
        settle();
        chkBit(sclOe, 1'b0, "rx free");
        master.stopC();
        close_out();
    end
endmodule // tb
